// ---- src/usb_bd_pkg.sv ----
// Constants, register map and field layout of the descriptor and interrupt block
package usb_bd_pkg;
  // ----------------------------------------
  // Table geometry
  // ----------------------------------------
  localparam int unsigned BD_ENTRIES = 64;
  localparam int unsigned BD_FIELDS  = 4;
  localparam int unsigned BD_BYTES   = BD_ENTRIES * BD_FIELDS;
  localparam logic [1:0]  FLD_STAT   = 2'h0;
  localparam logic [1:0]  FLD_CNT    = 2'h1;
  localparam logic [1:0]  FLD_ADRL   = 2'h2;
  localparam logic [1:0]  FLD_ADRH   = 2'h3;
  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam int unsigned APB_ADDR_W     = 12;
  localparam logic [11:0] ADDR_TBL_END   = 12'h3ff;
  localparam logic [11:0] ADDR_CTRL      = 12'h400;
  localparam logic [11:0] ADDR_STAT_FLG  = 12'h404;
  localparam logic [11:0] ADDR_STAT_EN   = 12'h408;
  localparam logic [11:0] ADDR_ERR_FLG   = 12'h40c;
  localparam logic [11:0] ADDR_ERR_EN    = 12'h410;
  localparam logic [11:0] ADDR_PERIPH2   = 12'h414;
  // ----------------------------------------
  // Field positions and reset values
  // ----------------------------------------
  localparam int unsigned OWN_BIT        = 7;
  localparam int unsigned TOGGLE_BIT     = 6;
  localparam int unsigned CHECK_BIT      = 3;
  localparam int unsigned STALL_BIT      = 2;
  localparam int unsigned CTRL_PPRST_BIT = 2;
  localparam int unsigned ERR_SUM_BIT    = 1;
  localparam int unsigned COMBINED_BIT   = 4;
  localparam logic [7:0]  STAT_MASK      = 8'h7d;
  localparam logic [7:0]  ERR_MASK       = 8'hff;
  localparam logic [7:0]  FLAG_RESET     = 8'h00;
  localparam logic [7:0]  EN_RESET       = 8'h00;
  localparam logic [31:0] PP_RESET       = 32'h0000_0000;
  typedef enum logic [1:0] {
    MODE_NONE    = 2'h0,
    MODE_EP0_OUT = 2'h1,
    MODE_ALL     = 2'h2,
    MODE_NOT_EP0 = 2'h3
  } mode_t;
endpackage : usb_bd_pkg

// ---- src/bd_index_map.sv ----
// Endpoint, direction and ping-pong pointer to descriptor index
`timescale 1ns/1ps
`default_nettype none
module bd_index_map
  import usb_bd_pkg::*;
(
  input  wire usb_bd_pkg::mode_t mode,
  input  wire logic [3:0]        ep,
  input  wire logic              dir_in,
  input  wire logic              odd,
  output logic [5:0]             index
);
  logic [6:0] k2;
  logic [6:0] k4;
  logic [6:0] t;

  assign k2 = {2'h0, ep, 1'b0};
  assign k4 = {1'b0, ep, 2'h0};

  always_comb
  begin
    t = 7'h00;
    case (mode)
      MODE_NONE:    t = k2 + {6'h00, dir_in};
      MODE_EP0_OUT:
        if (ep == 4'h0)
          t = dir_in ? 7'h02 : {6'h00, odd};
        else
          t = k2 + 7'h01 + {6'h00, dir_in};
      MODE_ALL:     t = k4 + {5'h00, dir_in, odd};
      MODE_NOT_EP0:
        if (ep == 4'h0)
          t = {6'h00, dir_in};
        else
          t = k4 - 7'h02 + {5'h00, dir_in, odd};
      default:      t = 7'h00;
    endcase
  end

  assign index = t[5:0];
endmodule : bd_index_map
`default_nettype wire

// ---- src/sticky_flags.sv ----
// Bank of sticky event flags, hardware set beats software write
`timescale 1ns/1ps
`default_nettype none
module sticky_flags #(
  parameter int unsigned   W    = 8,
  parameter logic [W-1:0]  MASK = '1
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] set,
  input  wire logic         wr,
  input  wire logic [W-1:0] wdata,
  output logic [W-1:0]      q
);
  logic [W-1:0] q_d;

  if (W < 1 || W > 32)
  begin : g_chk
    $error("sticky_flags width out of range");
  end

  always_comb
  begin
    q_d = ((wr ? wdata : q) | set) & MASK;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      q <= '0;
    else
      q <= q_d;
  end
endmodule : sticky_flags
`default_nettype wire

// ---- src/usb_bd_map_and_irq_funnel.sv ----
// Descriptor table, endpoint mapping and two-level interrupt funnel
// Operation
// - No ping-pong: endpoint k out uses 2k, in uses 2k+1.
// - Endpoint zero out doubled at 0/1, zero in at 2, others shift by one.
// - Full ping-pong: k out at 4k/4k+1, in at 4k+2/4k+3.
// - All but zero: zero at 0/1, k out 4k-2/4k-1, in 4k/4k+1.
// - Sixty-four entries of status, count, address low, address high.
// - Table has no reset value; firmware fills entries first.
// - Engine writes token id into status bits 5..2 while it owns.
// - Unowned bits 3 and 2 are toggle check and stall, read at handover.
// - Toggle value ignored unless toggle check enabled.
// - All sources merge into one combined request flag, bit 4.
// - Enables and flags live in separate registers.
// - Any enabled error flag raises the error summary flag.
// - Ten-bit count: low byte in count register, top bits in status.
// - Enabled status flags are ORed into the single request.
// - Flags stay set until firmware writes zero; firmware may set them.
// - Flags set regardless of enables, so they can be polled.
//
// Chosen here: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module usb_bd_map_and_irq_funnel (
  input  wire logic                             CLK,
  input  wire logic                             RST,
  input  wire logic                             PSEL,
  input  wire logic                             PENABLE,
  input  wire logic                             PWRITE,
  input  wire logic [usb_bd_pkg::APB_ADDR_W-1:0] PADDR,
  input  wire logic [31:0]                      PWDATA,
  output logic [31:0]                           PRDATA,
  output logic                                  PREADY,
  output logic                                  PSLVERR,
  input  wire logic [7:0]                       EVT_STATUS,
  input  wire logic [7:0]                       ERR_EVT,
  input  wire logic                             ENG_REQ,
  input  wire logic [4:0]                       ENG_EP,
  input  wire logic                             ENG_IN,
  input  wire logic                             ENG_DONE,
  input  wire logic [3:0]                       ENG_PID,
  input  wire logic [9:0]                       ENG_COUNT,
  output logic                                  ENG_VALID,
  output logic [5:0]                            ENG_INDEX,
  output logic                                  ENG_OWNS,
  output logic                                  ENG_TOGGLE_CHECK,
  output logic                                  ENG_TOGGLE_VALUE,
  output logic                                  ENG_STALL,
  output logic [9:0]                            ENG_BYTE_COUNT,
  output logic [15:0]                           ENG_BUF_ADDR,
  output logic                                  IRQ
);
  import usb_bd_pkg::*;

  // ----------------------------------------
  // Storage
  // ----------------------------------------
  logic [7:0]  bd_q [0:BD_BYTES-1];
  mode_t       mode_q;
  logic [31:0] pp_q;
  logic [7:0]  stat_q;
  logic [7:0]  err_q;
  logic [7:0]  stat_en_q;
  logic [7:0]  err_en_q;
  logic        held_q;
  logic [5:0]  cur_idx_q;
  logic [4:0]  cur_ptr_q;
  logic [5:0]  map_idx;
  logic [4:0]  ptr_sel;
  logic        ep_ok;
  logic        done_ok;
  logic        err_sum;
  logic [7:0]  stat_view;
  logic [7:0]  cur_stat;
  logic        setup;
  logic        access;
  logic        wr_en;
  logic        hit_tbl;
  logic        hit_any;
  logic [31:0] rdata;

  // ----------------------------------------
  // Mapping
  // ----------------------------------------
  // Only endpoints 0..15 served
  assign ep_ok   = !ENG_EP[4];
  assign ptr_sel = {ENG_EP[3:0], ENG_IN};

  bd_index_map u_map (
    .mode   (mode_q),
    .ep     (ENG_EP[3:0]),
    .dir_in (ENG_IN),
    .odd    (pp_q[ptr_sel]),
    .index  (map_idx)
  );

  assign cur_stat = bd_q[{cur_idx_q, FLD_STAT}];
  // Only an owned entry is written back
  assign done_ok  = ENG_DONE && held_q && cur_stat[OWN_BIT];

  // ----------------------------------------
  // APB decode
  // ----------------------------------------
  assign setup   = PSEL && !PENABLE;
  assign access  = PSEL && PENABLE && PREADY;
  assign wr_en   = access && PWRITE && !PSLVERR;
  assign hit_tbl = PADDR <= ADDR_TBL_END;

  assign err_sum   = |(err_q & err_en_q);
  assign stat_view = {stat_q[7:2], err_sum, stat_q[0]};

  always_comb
  begin
    rdata   = 32'h0000_0000;
    hit_any = 1'b1;
    if (hit_tbl)
      rdata[7:0] = bd_q[PADDR[9:2]];
    else
      case (PADDR)
        ADDR_CTRL:     rdata[1:0] = mode_q;
        ADDR_STAT_FLG: rdata[7:0] = stat_view;
        ADDR_STAT_EN:  rdata[7:0] = stat_en_q;
        ADDR_ERR_FLG:  rdata[7:0] = err_q;
        ADDR_ERR_EN:   rdata[7:0] = err_en_q;
        ADDR_PERIPH2:  rdata[COMBINED_BIT] = IRQ;
        default:       hit_any = 1'b0;
      endcase
  end

  // No wait state, PREADY high in the first access cycle; read value sampled in the setup cycle
  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      PREADY  <= 1'b0;
      PRDATA  <= 32'h0000_0000;
      PSLVERR <= 1'b0;
    end
    else
    begin
      PREADY  <= setup;
      PRDATA  <= setup ? rdata : 32'h0000_0000;
      PSLVERR <= setup && !hit_any;
    end
  end

  // ----------------------------------------
  // Control registers
  // ----------------------------------------
  // Enables apart from flags
  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      mode_q    <= MODE_NONE;
      stat_en_q <= EN_RESET;
      err_en_q  <= EN_RESET;
    end
    else if (wr_en)
    begin
      if (PADDR == ADDR_CTRL)
        mode_q <= mode_t'(PWDATA[1:0]);
      if (PADDR == ADDR_STAT_EN)
        stat_en_q <= PWDATA[7:0];
      if (PADDR == ADDR_ERR_EN)
        err_en_q <= PWDATA[7:0];
    end
  end

  // Pointer reset beats a toggle in the same cycle
  always_ff @(posedge CLK)
  begin
    if (RST)
      pp_q <= PP_RESET;
    else if (wr_en && PADDR == ADDR_CTRL && PWDATA[CTRL_PPRST_BIT])
      pp_q <= PP_RESET;
    else if (done_ok)
      pp_q[cur_ptr_q] <= !pp_q[cur_ptr_q];
  end

  // ----------------------------------------
  // Descriptor table
  // ----------------------------------------
  // Byte array, deliberately not reset
  always_ff @(posedge CLK)
  begin
    if (wr_en && hit_tbl)
      bd_q[PADDR[9:2]] <= PWDATA[7:0];
    if (done_ok)
    begin
      bd_q[{cur_idx_q, FLD_STAT}] <= {1'b0, cur_stat[TOGGLE_BIT], ENG_PID, ENG_COUNT[9:8]};
      bd_q[{cur_idx_q, FLD_CNT}]  <= ENG_COUNT[7:0];
    end
  end

  // ----------------------------------------
  // Engine lookup
  // ----------------------------------------
  // Config read at handover, value gated
  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      ENG_VALID        <= 1'b0;
      ENG_INDEX        <= 6'h00;
      ENG_OWNS         <= 1'b0;
      ENG_TOGGLE_CHECK <= 1'b0;
      ENG_TOGGLE_VALUE <= 1'b0;
      ENG_STALL        <= 1'b0;
      ENG_BYTE_COUNT   <= 10'h000;
      ENG_BUF_ADDR     <= 16'h0000;
      held_q           <= 1'b0;
      cur_idx_q        <= 6'h00;
      cur_ptr_q        <= 5'h00;
    end
    else
    begin
      ENG_VALID <= ENG_REQ && ep_ok;
      if (ENG_REQ && ep_ok)
      begin
        ENG_INDEX        <= map_idx;
        ENG_OWNS         <= bd_q[{map_idx, FLD_STAT}][OWN_BIT];
        ENG_TOGGLE_CHECK <= bd_q[{map_idx, FLD_STAT}][CHECK_BIT];
        ENG_TOGGLE_VALUE <= bd_q[{map_idx, FLD_STAT}][TOGGLE_BIT]
                            && bd_q[{map_idx, FLD_STAT}][CHECK_BIT];
        ENG_STALL        <= bd_q[{map_idx, FLD_STAT}][STALL_BIT];
        ENG_BYTE_COUNT   <= {bd_q[{map_idx, FLD_STAT}][1:0], bd_q[{map_idx, FLD_CNT}]};
        ENG_BUF_ADDR     <= {bd_q[{map_idx, FLD_ADRH}], bd_q[{map_idx, FLD_ADRL}]};
        held_q           <= 1'b1;
        cur_idx_q        <= map_idx;
        cur_ptr_q        <= ptr_sel;
      end
      else if (done_ok)
        held_q <= 1'b0;
    end
  end

  // ----------------------------------------
  // Interrupt funnel
  // ----------------------------------------
  // Flags set whatever the enables
  sticky_flags #(.W(8), .MASK(STAT_MASK)) u_stat (
    .clk   (CLK),
    .rst   (RST),
    .set   (EVT_STATUS),
    .wr    (wr_en && PADDR == ADDR_STAT_FLG),
    .wdata (PWDATA[7:0]),
    .q     (stat_q)
  );

  sticky_flags #(.W(8), .MASK(ERR_MASK)) u_err (
    .clk   (CLK),
    .rst   (RST),
    .set   (ERR_EVT),
    .wr    (wr_en && PADDR == ADDR_ERR_FLG),
    .wdata (PWDATA[7:0]),
    .q     (err_q)
  );

  always_ff @(posedge CLK)
  begin
    if (RST)
      IRQ <= 1'b0;
    else
      IRQ <= |(stat_view & stat_en_q);
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);

  map_none_a: assert property (mode_q == MODE_NONE |->
    map_idx == {1'b0, ENG_EP[3:0], ENG_IN})
    else $error("mode none index wrong");
  map_all_a: assert property (mode_q == MODE_ALL |->
    map_idx == {ENG_EP[3:0], ENG_IN, pp_q[ptr_sel]})
    else $error("full ping-pong index wrong");
  ep_range_a: assert property (ENG_REQ && ENG_EP[4] |=> !ENG_VALID)
    else $error("high endpoint served");
  lookup_idx_a: assert property (ENG_REQ && ep_ok |=>
    ENG_VALID && ENG_INDEX == $past(map_idx))
    else $error("lookup index wrong");
  toggle_gate_a: assert property (ENG_VALID && !ENG_TOGGLE_CHECK |->
    !ENG_TOGGLE_VALUE)
    else $error("toggle value not gated");
  pid_write_a: assert property (done_ok && !ENG_REQ |=>
    cur_stat[5:2] == $past(ENG_PID) && !cur_stat[OWN_BIT])
    else $error("token id not written");
  count_split_a: assert property (done_ok && !ENG_REQ |=>
    {cur_stat[1:0], bd_q[{cur_idx_q, FLD_CNT}]} == $past(ENG_COUNT))
    else $error("count not split");
  flag_sticky_a: assert property (EVT_STATUS[0] |=> stat_q[0] [*1] ##0
    (!wr_en || PADDR != ADDR_STAT_FLG || PWDATA[0]) [*1] |=> stat_q[0])
    else $error("flag lost");
  // Other enabled flags could raise the request, so enables all off here
  poll_set_a: assert property (EVT_STATUS[3] && stat_en_q == 8'h00 && !wr_en |=>
    stat_q[3] && !IRQ)
    else $error("masked flag not polled");
  err_sum_a: assert property ((ERR_EVT & err_en_q) != 8'h00 && !wr_en |=>
    stat_view[ERR_SUM_BIT])
    else $error("error summary missing");
  irq_or_a: assert property (|(stat_view & stat_en_q) |=>
    IRQ ##0 $past(stat_view) != 8'h00)
    else $error("request not combined");

  lookup_c: cover property (ENG_REQ && ep_ok ##1 ENG_VALID && ENG_OWNS);
  done_c: cover property (done_ok);
  irq_c: cover property ($rose(IRQ));
  err_c: cover property ($rose(err_sum));
endmodule : usb_bd_map_and_irq_funnel
`default_nettype wire

// ---- verification/eng_model.sv ----
// Protocol engine model driving lookups and completions
`timescale 1ns/1ps
`default_nettype none
module eng_model (
  input  wire logic clk,
  output logic       req,
  output logic [4:0] ep,
  output logic       in_dir,
  output logic       done,
  output logic [3:0] pid,
  output logic [9:0] cnt,
  input  wire logic  valid
);
  initial
  begin
    req = 0;
    ep = '0;
    in_dir = 0;
    done = 0;
    pid = '0;
    cnt = '0;
  end
  // ----------------------------------------
  // Lookup: one outstanding, released lines inverted
  // ----------------------------------------
  task lookup(input logic [4:0] e, input logic i, output logic ok);
    @(posedge clk);
    req <= 1'b1;
    ep <= e;
    in_dir <= i;
    @(posedge clk);
    req <= 1'b0;
    ep <= ~e;
    in_dir <= ~i;
    ok = 0;
    repeat (3)
    begin
      @(posedge clk);
      if (valid === 1'b1)
        ok = 1;
    end
  endtask : lookup
  // Completion pulse, after the lookup it answers
  task finish(input logic [3:0] p, input logic [9:0] c);
    @(posedge clk);
    done <= 1'b1;
    pid <= p;
    cnt <= c;
    @(posedge clk);
    done <= 1'b0;
    pid <= ~p;
    cnt <= ~c;
  endtask : finish
endmodule : eng_model
`default_nettype wire

// ---- verification/test_usb_bd_map_and_irq_funnel.sv ----
// Bench for the descriptor map and interrupt funnel
`timescale 1ns/1ps
`default_nettype none
module test_usb_bd_map_and_irq_funnel;
  import usb_bd_pkg::*;
  logic        clk = 0;
  logic        rst = 1;
  logic        psel = 0;
  logic        pen = 0;
  logic        pwr = 0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata, r;
  logic        pready, pslverr, irq, e, ok;
  logic [7:0]  evt = '0;
  logic [7:0]  eevt = '0;
  logic        req, din, done, valid, owns, tchk, tval, stall;
  logic [4:0]  ep;
  logic [3:0]  pid;
  logic [9:0]  cnt, bcnt;
  logic [5:0]  idx;
  logic [15:0] badr;
  int          error_cnt = 0;
  int          compares = 0;
  always #10 clk = ~clk;
  usb_bd_map_and_irq_funnel u_dut (
    .CLK(clk), .RST(rst), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .EVT_STATUS(evt), .ERR_EVT(eevt), .ENG_REQ(req),
    .ENG_EP(ep), .ENG_IN(din), .ENG_DONE(done), .ENG_PID(pid),
    .ENG_COUNT(cnt), .ENG_VALID(valid), .ENG_INDEX(idx), .ENG_OWNS(owns),
    .ENG_TOGGLE_CHECK(tchk), .ENG_TOGGLE_VALUE(tval), .ENG_STALL(stall),
    .ENG_BYTE_COUNT(bcnt), .ENG_BUF_ADDR(badr), .IRQ(irq));
  eng_model u_eng (.clk(clk), .req(req), .ep(ep), .in_dir(din), .done(done),
    .pid(pid), .cnt(cnt), .valid(valid));
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task chk(input string n, input logic [31:0] x, input logic [31:0] g);
    compares++;
    if (g !== x)
    begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", n, x, g);
    end
  endtask : chk
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    // No wait count assumed; only the watchdog ends a hang
    do
      @(posedge clk);
    while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask : apb
  task wr(input logic [11:0] a, input logic [7:0] d);
    apb(1'b1, a, {24'h0, d});
  endtask : wr
  task rdc(input string n, input logic [11:0] a, input logic [7:0] x);
    apb(1'b0, a, 32'h0);
    chk(n, {24'h0, x}, r);
  endtask : rdc
  task tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick
  // Only the even entry is reached here; odd comes from completions
  function automatic logic [5:0] exp_idx(int m, int k, int i);
    case (m)
      0: return 6'(2 * k + i);
      1: return (k == 0) ? 6'(2 * i) : 6'(2 * k + 1 + i);
      2: return 6'(4 * k + 2 * i);
      default: return (k == 0) ? 6'(i) : 6'(4 * k - 2 + 2 * i);
    endcase
  endfunction : exp_idx
  task test_done;
    $display("compares %0d errors %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : test_done
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_map;
    int ks[3] = '{0, 1, 15};
    for (int m = 0; m < 4; m++)
      for (int j = 0; j < 3; j++)
        for (int i = 0; i < 2; i++)
        begin
          wr(ADDR_CTRL, 8'(m) | 8'h04);
          u_eng.lookup(5'(ks[j]), i[0], ok);
          chk("valid", 1, ok);
          chk("index", exp_idx(m, ks[j], i), idx);
        end
  endtask : t_map
  task t_done;
    wr(ADDR_CTRL, 8'h06);
    wr(12'h040, 8'hcc);
    wr(12'h044, 8'h12);
    wr(12'h048, 8'h34);
    wr(12'h04c, 8'h56);
    u_eng.lookup(5'd1, 1'b0, ok);
    chk("index", 6'd4, idx);
    chk("owns", 1, owns);
    chk("check", 1, tchk);
    chk("stall", 1, stall);
    chk("toggle", 1, tval);
    chk("count", 10'h012, bcnt);
    chk("addr", 16'h5634, badr);
    u_eng.finish(4'h9, 10'h2ab);
    tick(1);
    rdc("status", 12'h040, 8'h66);
    rdc("count", 12'h044, 8'hab);
    // Config rewritten before next handover
    wr(12'h050, 8'hc0);
    u_eng.lookup(5'd1, 1'b0, ok);
    chk("odd valid", 1, ok);
    chk("odd index", 6'd5, idx);
    chk("toggle", 0, tval);
  endtask : t_done
  task t_bad;
    apb(1'b0, 12'h418, 32'h0);
    chk("rd err", 1, e);
    chk("rd data", 0, r);
    apb(1'b1, 12'h418, 32'hff);
    chk("wr err", 1, e);
    u_eng.lookup(5'd16, 1'b1, ok);
    chk("ep16 valid", 0, ok);
    chk("ep16 index", 6'd5, idx);
  endtask : t_bad
  task t_irq;
    rdc("en", ADDR_STAT_EN, 8'h00);
    rdc("err en", ADDR_ERR_EN, 8'h00);
    @(posedge clk);
    evt <= 8'h09;
    @(posedge clk);
    evt <= 8'h00;
    tick(2);
    rdc("flags", ADDR_STAT_FLG, 8'h09);
    chk("irq masked", 0, irq);
    wr(ADDR_STAT_EN, 8'h01);
    tick(2);
    chk("irq", 1, irq);
    rdc("combined", ADDR_PERIPH2, 8'h10);
    rdc("sticky", ADDR_STAT_FLG, 8'h09);
    wr(ADDR_STAT_FLG, 8'h04);
    rdc("sw set", ADDR_STAT_FLG, 8'h04);
    tick(2);
    chk("irq off", 0, irq);
    wr(ADDR_STAT_FLG, 8'h00);
  endtask : t_irq
  task t_err;
    @(posedge clk);
    eevt <= 8'h08;
    @(posedge clk);
    eevt <= 8'h00;
    tick(2);
    rdc("err flags", ADDR_ERR_FLG, 8'h08);
    rdc("no sum", ADDR_STAT_FLG, 8'h00);
    wr(ADDR_ERR_EN, 8'h08);
    rdc("sum", ADDR_STAT_FLG, 8'h02);
    wr(ADDR_STAT_EN, 8'h02);
    tick(2);
    chk("err irq", 1, irq);
    wr(ADDR_ERR_FLG, 8'h00);
    tick(2);
    chk("err irq off", 0, irq);
    // Error event while already enabled
    @(posedge clk);
    eevt <= 8'h08;
    @(posedge clk);
    eevt <= 8'h00;
    tick(2);
    chk("err irq again", 1, irq);
    wr(ADDR_ERR_FLG, 8'h00);
    tick(2);
    chk("err irq cleared", 0, irq);
  endtask : t_err
  // ----------------------------------------
  // Sequence and watchdog
  // ----------------------------------------
  initial
  begin
    tick(2);
    rst <= 1'b0;
    t_map();
    t_done();
    t_bad();
    t_irq();
    t_err();
    test_done();
  end
  initial
  begin
    #100us;
    error_cnt++;
    $display("[ERR] watchdog expected finish seen hang");
    test_done();
  end
endmodule : test_usb_bd_map_and_irq_funnel
`default_nettype wire
